// [rtl/stream_out_pkg.sv]
/*
  Constants and types for the converter's result streaming block:
  output select codes, exit and reset patterns, frame layout.
  Assumes a single core clock domain; no bus, plain ports only.
*/
// Operation
// - Select codes: 00 off, 01 read, 10 transmit.
// - Continuous read returns data without instruction byte.
// - Read still running at next result is aborted.
// - Byte 0xA5 first after ready falls exits read.
// - 63 ones then zero, three times, exits both.
// - Interface setup reset also leaves continuous read.
// - Transmit pushes results, aux pins clock and sync.
// - Frame is one or two 32-bit slots.
// - Data clock derived from main clock, optional divide.
// - Transmit ignores serial clock; output carries data only.
// - Writing select 00 stops automatic transmission.
// - Status after data in read, first in transmit.
// - Continuous conversion updates data, drives ready low.
package stream_out_pkg;
  localparam logic [1:0] SEL_OFF         = 2'h0;  // Streaming off
  localparam logic [1:0] SEL_READ        = 2'h1;  // Host-clocked read
  localparam logic [1:0] SEL_TX          = 2'h2;  // Device-driven transmit
  localparam logic [3:0] MODE_CONTINUOUS = 4'h0;  // Continuous conversion code
  localparam logic [7:0] EXIT_CMD        = 8'ha5; // Leaves continuous read
  localparam logic [5:0] RESET_ONES      = 6'h3f; // Ones before the closing zero
  localparam logic [1:0] RESET_REPEATS   = 2'h3;  // Pattern repeats needed
  localparam int         DATA_BITS       = 24;    // Conversion result width
  localparam int         STATUS_BITS     = 8;     // Status byte width
  localparam int         SLOT_BITS       = 32;    // One transmit slot
  localparam logic [2:0] BYTE_LAST       = 3'h7;  // Bit index closing a byte
  localparam logic [5:0] READ_LEN_DATA   = 6'h18; // Bits read without status
  localparam logic [5:0] READ_LEN_STAT   = 6'h20; // Bits read with status
  localparam logic [6:0] FRAME_ONE_SLOT  = 7'h20; // Frame bits, one slot
  localparam logic [6:0] FRAME_TWO_SLOT  = 7'h40; // Frame bits, two slots

  // Active streaming state
  typedef enum logic [1:0] {
    ST_OFF,
    ST_READ,
    ST_TX
  } stream_e;
endpackage

// [rtl/stream_out.sv]
/*
  Result FIFO and streaming control for continuous read and continuous
  transmit. Assumes results arrive on core_clk; serial pins are
  asynchronous and are synchronised here. Pins are split into in/out/oe.
*/
`timescale 1ns/1ps

module stream_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  // Whole FIFO state, flags kept as flops
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        full;
    logic                        empty;
  } fifo_s;

  fifo_s cur_ff;
  fifo_s nxt_ff;
  logic  push;
  logic  pop;

  assign push      = in_valid && !cur_ff.full;
  assign pop       = out_ready && !cur_ff.empty;
  assign in_ready  = !cur_ff.full;
  assign out_valid = !cur_ff.empty;
  assign out_data  = cur_ff.mem[cur_ff.rd];

  // Pointer and count update; flags follow the new count
  always_comb begin
    nxt_ff = cur_ff;
    if (push) begin
      nxt_ff.mem[cur_ff.wr] = in_data;
      nxt_ff.wr             = cur_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_ff.rd = cur_ff.rd + 1'b1;
    end
    nxt_ff.cnt   = cur_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    nxt_ff.full  = nxt_ff.cnt == (AW+1)'(DEPTH);
    nxt_ff.empty = nxt_ff.cnt == '0;
  end

  // Empty after reset
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff       <= '0;
      cur_ff.empty <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end
endmodule

module adc_continuous_read_transmit #(
  parameter int          FIFO_DEPTH   = 16,
  parameter logic [15:0] DATA_CLK_DIV = 16'h1  // Core cycles per data clock half period
) (
  input  wire logic                                 core_clk,
  input  wire logic                                 rst_b,
  input  wire logic [stream_out_pkg::DATA_BITS-1:0]   result_data,
  input  wire logic [stream_out_pkg::STATUS_BITS-1:0] result_status,
  input  wire logic                                 result_valid,
  output logic                                      result_ready,
  input  wire logic [stream_out_pkg::STATUS_BITS-1:0] crc_byte,
  input  wire logic                                 ctrl_write,
  input  wire logic [1:0]                           stream_output_select,
  input  wire logic                                 append_status_enable,
  input  wire logic                                 crc_enable,
  input  wire logic [3:0]                           conversion_mode,
  output logic [1:0]                                active_select,
  output logic                                      ready_b,
  input  wire logic                                 spi_sclk,
  input  wire logic                                 spi_cs_b,
  input  wire logic                                 spi_mosi,
  output logic                                      spi_miso_o,
  output logic                                      spi_miso_oe,
  output logic                                      aux_pin_one_o,
  output logic                                      aux_pin_one_oe,
  output logic                                      aux_pin_two_o,
  output logic                                      aux_pin_two_oe
);
  localparam int WORD = stream_out_pkg::DATA_BITS + stream_out_pkg::STATUS_BITS;

  // All block state; sync bits ordered {cs_b, sclk, mosi}
  typedef struct packed {
    logic [2:0]                  sync1;     // First synchroniser stage
    logic [2:0]                  sync2;     // Second stage, safe to use
    logic [2:0]                  prev;      // Second stage delayed, for edges
    stream_out_pkg::stream_e     mode;
    logic [1:0]                  sel;       // Reported select code
    logic                        rdy_b;
    logic [WORD-1:0]             data_reg;  // {data, status}
    logic [WORD-1:0]             shift;     // Read shifter
    logic [5:0]                  bits;      // Bits clocked in this read
    logic                        reading;
    logic                        aborted;
    logic [7:0]                  rx_byte;
    logic [2:0]                  rx_cnt;
    logic                        first_byte; // Next byte may be the exit command
    logic [5:0]                  ones;
    logic [1:0]                  reps;
    logic [2*WORD-1:0]           tx_shift;
    logic [6:0]                  tx_left;
    logic [6:0]                  tx_len;
    logic [15:0]                 div_cnt;
    logic                        data_clk;
    logic                        fsync;
    logic                        sdo;
    logic                        sdo_oe;
    logic                        aux_oe;    // Aux pin drive, follows transmit mode
    logic                        in_rdy;    // FIFO not full, one cycle late
  } ctrl_s;

  ctrl_s           cur_ff;
  ctrl_s           nxt_ff;
  logic [WORD-1:0] fifo_data;
  logic            fifo_valid;
  logic            fifo_take;
  logic            fifo_in_ready;

  // Sixteen-word buffer between converter and serial side
  stream_fifo #(
    .WIDTH (WORD),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_b     (rst_b),
    .in_data   ({result_data, result_status}),
    .in_valid  (result_valid),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );

  // Transmit stalls the buffer until the frame on the wire is done
  assign fifo_take = cur_ff.mode != stream_out_pkg::ST_TX || cur_ff.tx_left == '0;

  // Read length depends on the appended status byte
  function automatic logic [5:0] read_len(input logic stat_en);
    read_len = stat_en ? stream_out_pkg::READ_LEN_STAT : stream_out_pkg::READ_LEN_DATA;
  endfunction

  // Main next-state logic
  always_comb begin
    logic cs_low;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic mosi;
    logic [7:0] byte_in;
    logic [WORD-1:0] slot_one;
    logic [WORD-1:0] slot_two;
    logic tick;
    cs_low    = 1'b0;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    cs_fall   = 1'b0;
    cs_rise   = 1'b0;
    mosi      = 1'b0;
    byte_in   = '0;
    slot_one  = '0;
    slot_two  = '0;
    tick      = 1'b0;
    nxt_ff    = cur_ff;

    // Two-stage synchronisers; edges only from the second stage
    nxt_ff.sync1 = {spi_cs_b, spi_sclk, spi_mosi};
    nxt_ff.sync2 = cur_ff.sync1;
    nxt_ff.prev  = cur_ff.sync2;
    cs_low    = !cur_ff.sync2[2];
    cs_fall   = cur_ff.prev[2] && !cur_ff.sync2[2];
    cs_rise   = !cur_ff.prev[2] && cur_ff.sync2[2];
    sclk_rise = cs_low && !cur_ff.prev[1] && cur_ff.sync2[1];
    sclk_fall = cs_low && cur_ff.prev[1] && !cur_ff.sync2[1];
    mosi      = cur_ff.sync2[0];

    // Software select write; reserved code is ignored
    if (ctrl_write) begin
      if (stream_output_select == stream_out_pkg::SEL_OFF) begin
        nxt_ff.mode = stream_out_pkg::ST_OFF;
      end else if (conversion_mode == stream_out_pkg::MODE_CONTINUOUS) begin
        if (stream_output_select == stream_out_pkg::SEL_READ) begin
          nxt_ff.mode = stream_out_pkg::ST_READ;
        end else if (stream_output_select == stream_out_pkg::SEL_TX) begin
          nxt_ff.mode = stream_out_pkg::ST_TX;
        end
      end
    end

    // Serial interface reset pattern, watched in every mode
    if (sclk_rise) begin
      if (mosi) begin
        if (cur_ff.ones != stream_out_pkg::RESET_ONES) begin
          nxt_ff.ones = cur_ff.ones + 6'h1;
        end
      end else begin
        nxt_ff.ones = '0;
        if (cur_ff.ones == stream_out_pkg::RESET_ONES) begin
          nxt_ff.reps = cur_ff.reps + 2'h1;
          if (cur_ff.reps + 2'h1 == stream_out_pkg::RESET_REPEATS) begin
            nxt_ff.mode = stream_out_pkg::ST_OFF;
            nxt_ff.reps = '0;
          end
        end else begin
          nxt_ff.reps = '0;
        end
      end
    end

    // New result: data register updated, ready driven low
    if (fifo_valid && fifo_take) begin
      nxt_ff.data_reg   = fifo_data;
      nxt_ff.rdy_b      = 1'b0;
      nxt_ff.first_byte = 1'b1;
      if (cur_ff.reading) begin
        nxt_ff.aborted = 1'b1;
        nxt_ff.reading = 1'b0;
      end
    end

    case (cur_ff.mode)
      stream_out_pkg::ST_READ: begin
        // No instruction needed: chip select starts a data read
        if (cs_fall) begin
          nxt_ff.shift   = cur_ff.data_reg;
          nxt_ff.bits    = '0;
          nxt_ff.reading = 1'b1;
          nxt_ff.aborted = 1'b0;
          nxt_ff.rx_cnt  = '0;
          nxt_ff.sdo     = cur_ff.data_reg[WORD-1];
        end
        // Status bits follow data when enabled
        if (sclk_rise && cur_ff.reading) begin
          nxt_ff.bits = cur_ff.bits + 6'h1;
          if (cur_ff.bits + 6'h1 == read_len(append_status_enable)) begin
            nxt_ff.reading = 1'b0;
            nxt_ff.rdy_b   = !(fifo_valid && fifo_take);  // A result landing now wins
          end
        end
        if (sclk_fall && cur_ff.reading) begin
          nxt_ff.shift = {cur_ff.shift[WORD-2:0], 1'b0};
          nxt_ff.sdo   = cur_ff.shift[WORD-2];
        end
        // Incoming bytes are only checked for the exit command
        if (sclk_rise) begin
          byte_in        = {cur_ff.rx_byte[6:0], mosi};
          nxt_ff.rx_byte = byte_in;
          nxt_ff.rx_cnt  = cur_ff.rx_cnt + 3'h1;
          if (cur_ff.rx_cnt == stream_out_pkg::BYTE_LAST) begin
            nxt_ff.first_byte = fifo_valid && fifo_take;  // A result landing now re-arms
            if (cur_ff.first_byte && byte_in == stream_out_pkg::EXIT_CMD) begin
              nxt_ff.mode = stream_out_pkg::ST_OFF;
            end
          end
        end
        if (cs_rise) begin
          nxt_ff.reading = 1'b0;
          nxt_ff.aborted = 1'b0;
        end
        nxt_ff.sdo_oe = cs_low && !nxt_ff.aborted;
        nxt_ff.div_cnt = '0;
        nxt_ff.data_clk = 1'b0;
        nxt_ff.fsync   = 1'b0;
      end
      stream_out_pkg::ST_TX: begin
        // Serial clock plays no part in transfer here; output is data only
        nxt_ff.reading = 1'b0;
        nxt_ff.sdo_oe  = 1'b1;
        // Frame built from the new result, status first when enabled
        if (fifo_valid && fifo_take) begin
          slot_one = append_status_enable ?
                     {fifo_data[stream_out_pkg::STATUS_BITS-1:0],
                      fifo_data[WORD-1:stream_out_pkg::STATUS_BITS]} :
                     {fifo_data[WORD-1:stream_out_pkg::STATUS_BITS],
                      {stream_out_pkg::STATUS_BITS{1'b0}}};
          slot_two = {(append_status_enable ? fifo_data[stream_out_pkg::STATUS_BITS-1:0] : 8'h00),
                      crc_byte, 16'h0000};
          nxt_ff.tx_shift = {slot_one, slot_two};
          nxt_ff.tx_len   = crc_enable ? stream_out_pkg::FRAME_TWO_SLOT :
                            stream_out_pkg::FRAME_ONE_SLOT;
          nxt_ff.tx_left  = nxt_ff.tx_len;
        end
        // Data clock divided down from the core clock
        tick = cur_ff.div_cnt == DATA_CLK_DIV - 16'h1;
        nxt_ff.div_cnt = tick ? 16'h0 : cur_ff.div_cnt + 16'h1;
        if (tick) begin
          nxt_ff.data_clk = !cur_ff.data_clk;
          // Bits change on the falling data clock edge
          if (cur_ff.data_clk) begin
            if (cur_ff.tx_left != '0) begin
              nxt_ff.sdo      = cur_ff.tx_shift[2*WORD-1];
              nxt_ff.tx_shift = {cur_ff.tx_shift[2*WORD-2:0], 1'b0};
              nxt_ff.fsync    = cur_ff.tx_left == cur_ff.tx_len;
              nxt_ff.tx_left  = cur_ff.tx_left - 7'h1;
              if (cur_ff.tx_left == 7'h1) begin
                nxt_ff.rdy_b = 1'b1;
              end
            end else begin
              nxt_ff.sdo   = 1'b0;
              nxt_ff.fsync = 1'b0;
            end
          end
        end
      end
      default: begin
        // Off: pins released, any frame in flight dropped
        nxt_ff.sdo_oe  = 1'b0;
        nxt_ff.reading = 1'b0;
        nxt_ff.tx_left = '0;
        nxt_ff.div_cnt = '0;
        nxt_ff.data_clk = 1'b0;
        nxt_ff.fsync   = 1'b0;
        nxt_ff.sdo     = 1'b0;
      end
    endcase

    // Select report follows the state; no other reset path touches it
    case (nxt_ff.mode)
      stream_out_pkg::ST_READ: nxt_ff.sel = stream_out_pkg::SEL_READ;
      stream_out_pkg::ST_TX:   nxt_ff.sel = stream_out_pkg::SEL_TX;
      default:                 nxt_ff.sel = stream_out_pkg::SEL_OFF;
    endcase
    // Enables follow the next mode, so no pin stays driven after switching to off; data output enable comes from the old mode on other switches
    nxt_ff.aux_oe = nxt_ff.mode == stream_out_pkg::ST_TX;
    nxt_ff.sdo_oe = nxt_ff.sdo_oe && nxt_ff.mode != stream_out_pkg::ST_OFF;
    // Back-pressure registered so the output comes from a flop
    nxt_ff.in_rdy = fifo_in_ready;
  end

  // State register; ready idles high
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cur_ff       <= '0;
      cur_ff.sync1 <= 3'h7;
      cur_ff.sync2 <= 3'h7;
      cur_ff.prev  <= 3'h7;
      cur_ff.rdy_b <= 1'b1;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign result_ready   = cur_ff.in_rdy;
  assign active_select  = cur_ff.sel;
  assign ready_b        = cur_ff.rdy_b;
  assign spi_miso_o     = cur_ff.sdo;
  assign spi_miso_oe    = cur_ff.sdo_oe;
  assign aux_pin_one_o  = cur_ff.fsync;
  assign aux_pin_one_oe = cur_ff.aux_oe;
  assign aux_pin_two_o  = cur_ff.data_clk;
  assign aux_pin_two_oe = cur_ff.aux_oe;
endmodule

// [bench/stream_out_checker.sv]
/*
  Port-level checks for the result streaming block, bound to its top.
  Assumes one clock domain with an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module stream_out_checker #(
  parameter logic [15:0] DATA_CLK_DIV = 16'h1
) (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       result_valid,
  input wire logic       result_ready,
  input wire logic       ctrl_write,
  input wire logic [1:0] stream_output_select,
  input wire logic [3:0] conversion_mode,
  input wire logic [1:0] active_select,
  input wire logic       ready_b,
  input wire logic       spi_cs_b,
  input wire logic       spi_miso_oe,
  input wire logic       aux_pin_one_o,
  input wire logic       aux_pin_one_oe,
  input wire logic       aux_pin_two_o,
  input wire logic       aux_pin_two_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic        two_q_ff;  // Last data clock level
  logic        armed_ff;  // A toggle already seen in transmit
  logic [15:0] hcnt_ff;   // Cycles since last toggle
  wire logic   tog = aux_pin_two_o != two_q_ff;
  // First toggle after entry only arms: its spacing to entry is free
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      two_q_ff <= 1'b0;
      armed_ff <= 1'b0;
      hcnt_ff  <= 16'h0;
    end else begin
      two_q_ff <= aux_pin_two_o;
      armed_ff <= aux_pin_two_oe && (tog || armed_ff);
      hcnt_ff  <= tog ? 16'h0 : hcnt_ff + 16'h1;
    end
  end
  select_apply_a: assert property (ctrl_write && stream_output_select != 2'h3
    && (stream_output_select == 2'h0 || conversion_mode == 4'h0)
    |=> active_select == $past(stream_output_select)) else $error("select not applied");
  reserved_code_a: assert property (ctrl_write && stream_output_select == 2'h3
    |=> $stable(active_select)) else $error("reserved select changed mode");
  mode_gate_a: assert property (ctrl_write && stream_output_select != 2'h0
    && conversion_mode != 4'h0 |=> $stable(active_select)) else $error("mode gate ignored");
  tx_pins_a: assert property (active_select == 2'h2 && $past(active_select) == 2'h2
    |-> aux_pin_one_oe && aux_pin_two_oe) else $error("aux pins not driven");
  tx_release_a: assert property (active_select == 2'h0 && $past(active_select) == 2'h0
    |-> !aux_pin_one_oe && !aux_pin_two_oe) else $error("aux pins still driven");
  transmit_data_clock_half_a: assert property (armed_ff && tog && aux_pin_two_oe
    |-> hcnt_ff == DATA_CLK_DIV - 16'h1) else $error("data clock half period wrong");
  fsync_edge_a: assert property ($rose(aux_pin_one_o) && aux_pin_one_oe
    |-> $fell(aux_pin_two_o)) else $error("frame sync off data clock fall");
  ready_fall_a: assert property (result_valid && result_ready && ready_b && spi_cs_b
    && active_select == 2'h1 |-> ##[1:4] !ready_b) else $error("ready not lowered");
  sdo_idle_a: assert property (spi_cs_b [*6] |-> !spi_miso_oe
    || active_select == 2'h2) else $error("output driven while deselected");
endmodule
bind adc_continuous_read_transmit stream_out_checker #(.DATA_CLK_DIV(DATA_CLK_DIV)) i_stream_out_checker (
  .core_clk, .rst_b, .result_valid, .result_ready, .ctrl_write, .stream_output_select,
  .conversion_mode, .active_select, .ready_b, .spi_cs_b, .spi_miso_oe, .aux_pin_one_o,
  .aux_pin_one_oe, .aux_pin_two_o, .aux_pin_two_oe);

// [bench/host_model.sv]
/*
  Host model: SPI master in clock mode 0 and a TDM frame receiver.
  Assumes host timing is paced by core_clk, far above sync latency.
*/
`timescale 1ns/1ps
module host_model (
  input  wire logic       core_clk,
  input  wire logic       miso_o,
  input  wire logic       data_clk,
  input  wire logic       data_clk_oe,
  input  wire logic       fsync,
  input  wire logic [6:0] frame_len,
  output logic            sclk,
  output logic            cs_b,
  output logic            mosi,
  output logic [63:0]     frame,
  output int              frame_cnt
);
  logic [63:0] sh;  // Receiver shift register
  int          nb;  // Bits since frame sync, 0 when idle
  // Clock parked low outside frames; first bit stands from select fall
  initial begin
    sclk      = 1'b0;
    cs_b      = 1'b1;
    mosi      = 1'b0;
    frame     = 64'h0;
    frame_cnt = 0;
    nb        = 0;
  end
  // Select held low over the whole word, optionally beyond
  task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx, input logic hold);
    rx = 64'h0;
    @(posedge core_clk) cs_b <= 1'b0;
    repeat (8) @(posedge core_clk);
    for (int i = n - 1; i >= 0; i--) begin
      sclk <= 1'b0;
      mosi <= tx[i];
      repeat (5) @(posedge core_clk);
      rx = {rx[62:0], miso_o};
      sclk <= 1'b1;
      repeat (5) @(posedge core_clk);
    end
    sclk <= 1'b0;
    cs_b <= hold;
    mosi <= ~mosi;  // Released line must not keep the last bit
  endtask
  // Three ones-then-zero patterns in one select window
  task automatic serial_reset();
    logic [63:0] rx;
    xfer(64, {{63{1'b1}}, 1'b0}, rx, 1'b0);
    xfer(64, {{63{1'b1}}, 1'b0}, rx, 1'b0);
    xfer(64, {{63{1'b1}}, 1'b0}, rx, 1'b1);
  endtask
  // Sample on rising data clock; sync marks the first bit
  always @(posedge data_clk) begin
    if (data_clk_oe) begin
      sh = fsync ? {63'h0, miso_o} : {sh[62:0], miso_o};
      if (fsync) nb = 1;
      else if (nb != 0) nb++;
      if (nb == int'(frame_len)) begin
        frame     <= sh;
        frame_cnt <= frame_cnt + 1;
        nb = 0;
      end
    end
  end
endmodule

// [bench/tb.sv]
/*
  Self-checking bench: random results through read, abort, exits,
  transmit frames and FIFO back-pressure. Needs host_model and checker.
*/
`timescale 1ns/1ps
module tb;
  localparam logic [15:0] DIV = 16'h2;  // A 32-bit frame takes 128 core cycles, far beyond result spacing
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [23:0] result_data = 24'h0;
  logic [7:0]  result_status = 8'h0;
  logic        result_valid = 1'b0;
  logic [7:0]  crc_byte = 8'h0;
  logic        ctrl_write = 1'b0;
  logic [1:0]  stream_output_select = 2'h0;
  logic        append_status_enable = 1'b0;
  logic        crc_enable = 1'b0;
  logic [3:0]  conversion_mode = 4'h0;
  logic        result_ready, ready_b, spi_sclk, spi_cs_b, spi_mosi, spi_miso_o, spi_miso_oe;
  logic        aux_pin_one_o, aux_pin_one_oe, aux_pin_two_o, aux_pin_two_oe, saw_full = 1'b0;
  logic [1:0]  active_select;
  logic [63:0] frame;
  int          frame_cnt, fails = 0, cmp_count = 0;
  logic [63:0] exq[$];  // Frames expected, in order
  always #2 core_clk = ~core_clk;
  adc_continuous_read_transmit #(.FIFO_DEPTH(16), .DATA_CLK_DIV(DIV)) i_adc_continuous_read_transmit (
    .core_clk, .rst_b, .result_data, .result_status, .result_valid, .result_ready, .crc_byte,
    .ctrl_write, .stream_output_select, .append_status_enable, .crc_enable, .conversion_mode,
    .active_select, .ready_b, .spi_sclk, .spi_cs_b, .spi_mosi, .spi_miso_o, .spi_miso_oe,
    .aux_pin_one_o, .aux_pin_one_oe, .aux_pin_two_o, .aux_pin_two_oe);
  // An undriven data line shows the inverse, so a late enable is caught
  host_model i_host_model (.core_clk, .miso_o(spi_miso_oe ? spi_miso_o : ~spi_miso_o),
    .data_clk(aux_pin_two_o), .data_clk_oe(aux_pin_two_oe), .fsync(aux_pin_one_o),
    .frame_len(crc_enable ? 7'h40 : 7'h20),
    .sclk(spi_sclk), .cs_b(spi_cs_b), .mosi(spi_mosi), .frame, .frame_cnt);
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t ns: value mismatch", $time);
    end
  endtask
  task automatic give_verdict();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic set_mode(input logic [1:0] s, input logic [3:0] m);
    @(posedge core_clk);
    stream_output_select <= s;
    conversion_mode      <= m;
    ctrl_write           <= 1'b1;
    @(posedge core_clk) ctrl_write <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  // Ready is a cycle late, so two idle cycles sit between offers
  task automatic push(input logic [23:0] d, input logic [7:0] s);
    @(posedge core_clk);
    while (result_ready !== 1'b1) begin
      saw_full = 1'b1;
      @(posedge core_clk);
    end
    result_data   <= d;
    result_status <= s;
    result_valid  <= 1'b1;
    @(posedge core_clk) result_valid <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wait_rdy();
    for (int i = 0; i < 300 && ready_b !== 1'b0; i++) @(posedge core_clk);
  endtask
  function automatic logic [63:0] frame_of(logic [23:0] d, logic [7:0] s, logic [7:0] c,
                                           logic st, logic cr);
    logic [31:0] s1;
    s1 = st ? {s, d} : {d, 8'h0};
    return cr ? {s1, (st ? s : 8'h0), c, 16'h0} : {32'h0, s1};
  endfunction
  // Each received frame against the oldest expected one
  always @(frame_cnt) begin
    if (frame_cnt > 0) begin
      if (exq.size() != 0) chk(frame, exq.pop_front());
      else chk(1'b1, 1'b0);
    end
  end
  initial begin
    repeat (40000) @(posedge core_clk);
    fails++;
    give_verdict();
  end
  initial begin
    logic [63:0] rx;
    logic [23:0] d;
    logic [7:0]  s;
    void'($urandom(14));
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(active_select, 2'h0);
    set_mode(2'h3, 4'h0);
    chk(active_select, 2'h0);
    set_mode(2'h1, 4'h4 + 4'($urandom_range(3)));
    chk(active_select, 2'h0);
    set_mode(2'h1, 4'h0);
    chk(active_select, 2'h1);
    for (int k = 0; k < 2; k++) begin
      append_status_enable <= k[0];
      d = 24'($urandom);
      s = 8'($urandom);
      push(d, s);
      wait_rdy();
      i_host_model.xfer(k ? 32 : 24, 64'h0, rx, 1'b1);
      chk(rx, k ? {32'h0, d, s} : {40'h0, d});
    end
    push(24'($urandom), 8'($urandom));
    wait_rdy();
    fork
      i_host_model.xfer(32, 64'h0, rx, 1'b1);
      begin
        repeat (60) @(posedge core_clk);
        push(24'($urandom), 8'($urandom));
        repeat (6) @(posedge core_clk);
        chk(spi_miso_oe, 1'b0);
      end
    join
    // The cut read's tail was the first byte after ready fell: arm again
    push(24'($urandom), 8'($urandom));
    repeat (4) @(posedge core_clk);
    i_host_model.xfer(8, 64'ha5, rx, 1'b1);
    repeat (10) @(posedge core_clk);
    chk(active_select, 2'h0);
    for (int k = 1; k < 3; k++) begin
      set_mode(2'(k), 4'h0);
      i_host_model.serial_reset();
      repeat (10) @(posedge core_clk);
      chk(active_select, 2'h0);
    end
    // Last pass outruns the frame rate to fill the FIFO
    for (int k = 0; k < 4; k++) begin
      append_status_enable <= k[0];
      crc_enable <= k[1];
      crc_byte   <= 8'($urandom);
      set_mode(2'h2, 4'h0);
      chk(active_select, 2'h2);
      repeat ((k == 3) ? 20 : 3) begin
        d = 24'($urandom);
        s = 8'($urandom);
        exq.push_back(frame_of(d, s, crc_byte, k[0], k[1]));
        push(d, s);
      end
      for (int i = 0; i < 9000 && exq.size() != 0; i++) @(posedge core_clk);
      chk(exq.size(), 0);
      set_mode(2'h0, 4'h0);
      chk(aux_pin_two_oe, 1'b0);
    end
    chk(saw_full, 1'b1);
    give_verdict();
  end
endmodule
